// file: design/rot_bank_map.sv
// bank address mapping for file register accesses
`timescale 1ns/10ps
`default_nettype none
module rot_bank_map
	import rot_set_pkg::*;
(
	input wire logic bank_sel,
	input wire logic [BANK_W-1:0] bank_select_register,
	input wire logic [ADDR_W-1:0] low_addr,
	output logic [FADDR_W-1:0] full_addr
);
	// ************************************************************
	// address formation
	// ************************************************************
	// access bank: low half at bank 0, high half at top bank
	always_comb
	begin
		if (bank_sel)
			full_addr = {bank_select_register, low_addr};
		else if (low_addr[ACCESS_SPLIT_BIT])
			full_addr = {ACCESS_HI_BANK, low_addr};
		else
			full_addr = {ZERO_BANK, low_addr};
	end
endmodule : rot_bank_map
`default_nettype wire

// file: design/rot_set_exec.sv
// decode and execute of rotate-right-no-carry and set-all-ones
// Notes on behaviour
// - opcode 0100 00da rotates file register right, bit 0 into bit 7, no carry
// - rotate with destination 0 writes accumulator, file register unchanged
// - rotate with destination 1 writes result back to the same register
// - rotate bank bit 0 uses access bank; 1 uses bank select register
// - opcode 0110 100a writes FFh into the addressed file register
// - set bank bit 0 uses access bank; 1 uses bank select register
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module rot_set_exec
	import rot_set_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [WORD_W-1:0] instr_word,
	input wire logic [BANK_W-1:0] bank_select_register,
	input wire logic [DATA_W-1:0] file_rd_data,
	output logic [FADDR_W-1:0] file_rd_addr,
	output logic file_wr_en,
	output logic [FADDR_W-1:0] file_wr_addr,
	output logic [DATA_W-1:0] file_wr_data,
	output logic [DATA_W-1:0] accum,
	output logic flag_neg,
	output logic flag_zero,
	output logic instr_done,
	output logic instr_other
);
	// ************************************************************
	// decode
	// ************************************************************
	op_t op;
	logic dest_bit;
	logic bank_bit;
	logic [DATA_W-1:0] rot_result;
	logic [DATA_W-1:0] accum_reg;
	logic neg_reg;
	logic zero_reg;
	logic wr_en_reg;
	logic [FADDR_W-1:0] wr_addr_reg;
	logic [DATA_W-1:0] wr_data_reg;
	logic done_reg;
	logic other_reg;

	// opcode match on the upper bits
	always_comb
	begin
		if (!instr_valid)
			op = OP_NONE;
		else if (instr_word[OPC_HI:OPC_LO] == ROTATE_OPC)
			op = OP_ROTATE;
		else if (instr_word[OPC_HI:SET_OPC_LO] == SET_OPC)
			op = OP_SET;
		else
			op = OP_NONE;
	end

	assign dest_bit = instr_word[DEST_BIT];
	assign bank_bit = instr_word[BANK_BIT];

	// bank select or access bank for both operations
	rot_bank_map u_bank_map (
		.bank_sel(bank_bit),
		.bank_select_register(bank_select_register),
		.low_addr(instr_word[ADDR_W-1:0]),
		.full_addr(file_rd_addr)
	);

	// ************************************************************
	// execute
	// ************************************************************
	// right rotate, bit 0 wraps to bit 7
	assign rot_result = {file_rd_data[0], file_rd_data[DATA_W-1:1]};

	// file register write port
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_en_reg <= 1'b0;
			wr_addr_reg <= '0;
			wr_data_reg <= ZERO_BYTE;
		end
		else if (clk_en)
		begin
			case (op)
				OP_ROTATE:
				begin
					wr_en_reg <= dest_bit;
					wr_addr_reg <= file_rd_addr;
					wr_data_reg <= rot_result;
				end
				OP_SET:
				begin
					wr_en_reg <= 1'b1;
					wr_addr_reg <= file_rd_addr;
					wr_data_reg <= ALL_ONES;
				end
				default:
				begin
					wr_en_reg <= 1'b0;
				end
			endcase
		end
	end

	// accumulator takes rotate result when destination is 0
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			accum_reg <= ZERO_BYTE;
		else if (clk_en && op == OP_ROTATE && !dest_bit)
			accum_reg <= rot_result;
	end

	// status flags from rotate only
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			neg_reg <= 1'b0;
			zero_reg <= 1'b0;
		end
		else if (clk_en && op == OP_ROTATE)
		begin
			neg_reg <= rot_result[NEG_BIT];
			zero_reg <= (rot_result == ZERO_BYTE);
		end
	end

	// completion strobes, one per instruction cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			done_reg <= 1'b0;
			other_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			done_reg <= (op != OP_NONE);
			other_reg <= instr_valid && (op == OP_NONE);
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign file_wr_en = wr_en_reg && clk_en;
	assign file_wr_addr = wr_addr_reg;
	assign file_wr_data = wr_data_reg;
	assign accum = accum_reg;
	assign flag_neg = neg_reg;
	assign flag_zero = zero_reg;
	assign instr_done = done_reg && clk_en;
	assign instr_other = other_reg && clk_en;
endmodule : rot_set_exec
`default_nettype wire

// file: shared/rot_set_pkg.sv
// package of constants for the rotate-right and set-all-ones decoder
package rot_set_pkg;
	// ************************************************************
	// instruction encoding
	// ************************************************************
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int BANK_W = 4;
	localparam int FADDR_W = 12;
	localparam int OPC_HI = 15;
	localparam int OPC_LO = 10;
	localparam int SET_OPC_LO = 9;
	localparam int DEST_BIT = 9;
	localparam int BANK_BIT = 8;
	localparam logic [5:0] ROTATE_OPC = 6'h10;
	localparam logic [6:0] SET_OPC = 7'h34;
	localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [BANK_W-1:0] ZERO_BANK = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hf;
	localparam int ACCESS_SPLIT_BIT = 7;
	localparam int NEG_BIT = 7;

	// ************************************************************
	// decoded operation
	// ************************************************************
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_ROTATE = 2'b01,
		OP_SET = 2'b10
	} op_t;
endpackage : rot_set_pkg

// file: test/rot_set_chk.sv
// assertion checker for the rotate and set decoder
`timescale 1ns/10ps
`default_nettype none
module rot_set_chk
	import rot_set_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [WORD_W-1:0] instr_word,
	input wire logic [BANK_W-1:0] bank_select_register,
	input wire logic [DATA_W-1:0] file_rd_data,
	input wire logic [FADDR_W-1:0] file_rd_addr,
	input wire logic file_wr_en,
	input wire logic [DATA_W-1:0] file_wr_data,
	input wire logic [DATA_W-1:0] accum,
	input wire logic flag_neg,
	input wire logic flag_zero
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// taken requests and the rotated byte
	wire logic go = clk_en && instr_valid;
	wire logic r = go && instr_word[15:10] == ROTATE_OPC;
	wire logic s = go && instr_word[15:9] == SET_OPC;
	wire logic [7:0] rr = {file_rd_data[0], file_rd_data[7:1]};
	a_rot_back: assert property (r && instr_word[9] |=> !clk_en || (file_wr_en && file_wr_data == $past(rr)))
		else $error("rotate writeback");
	a_rot_accum: assert property (r && !instr_word[9] |=> !file_wr_en && accum == $past(rr))
		else $error("rotate to accumulator");
	a_access_bank: assert property (!instr_word[8] |-> file_rd_addr == {instr_word[7] ? ACCESS_HI_BANK : ZERO_BANK, instr_word[7:0]})
		else $error("access bank address");
	a_select_bank: assert property (instr_word[8] |-> file_rd_addr == {bank_select_register, instr_word[7:0]})
		else $error("selected bank address");
	a_set_ones: assert property (s |=> !clk_en || (file_wr_en && file_wr_data == ALL_ONES))
		else $error("set write");
	a_rot_flags: assert property (r |=> flag_neg == $past(file_rd_data[0]) && flag_zero == ($past(rr) == ZERO_BYTE))
		else $error("rotate flags");
	a_set_flags: assert property (s |=> $stable({flag_neg, flag_zero}))
		else $error("set flags moved");
	// main scenarios
	c_rot_file: cover property (r && instr_word[9]);
	c_rot_acc: cover property (r && !instr_word[9]);
	c_set: cover property (s);
endmodule : rot_set_chk
bind rot_set_exec rot_set_chk chk (.*);
`default_nettype wire

// file: test/rotate_right_and_set_ops_tb.sv
// self-checking bench for the rotate and set decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; $display("wrong value %s %h %h", n, e, s); end end
module rotate_right_and_set_ops_tb;
	import rot_set_pkg::*;
	logic clk_sys = 0, rst_n = 0, clk_en = 1, instr_valid = 0;
	logic [15:0] instr_word = 16'h0;
	logic [3:0] bank_select_register = 4'h5;
	logic [7:0] file_rd_data = 8'h0, file_wr_data, accum;
	logic [11:0] file_rd_addr, file_wr_addr;
	logic file_wr_en, flag_neg, flag_zero, instr_done, instr_other;
	int errors = 0, n_checks = 0;
	rot_set_exec dut (.*);
	initial forever #10 clk_sys = ~clk_sys;
	// one instruction: word, read byte, expected read address
	task automatic op(input logic [15:0] w, input logic [7:0] d, input logic [11:0] a);
		@(posedge clk_sys);
		instr_word <= w;
		file_rd_data <= d;
		instr_valid <= 1'b1;
		#1;
		`CHK("rd_addr", a, file_rd_addr)
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
	endtask : op
	task automatic t_rot;
		op(16'h4312, 8'hd7, 12'h512);
		`CHK("wr", 21'h1512eb, {file_wr_en, file_wr_addr, file_wr_data})
		`CHK("nzd", 3'h5, {flag_neg, flag_zero, instr_done})
		op(16'h4090, 8'h01, 12'hf90);
		`CHK("acc", 9'h080, {file_wr_en, accum})
		op(16'h4105, 8'h00, 12'h505);
		`CHK("nz", 2'h1, {flag_neg, flag_zero})
		$display("rotate tests done");
	endtask : t_rot
	task automatic t_set;
		op(16'h68a0, 8'h5a, 12'hfa0);
		`CHK("wr", 21'h1fa0ff, {file_wr_en, file_wr_addr, file_wr_data})
		op(16'h6920, 8'h00, 12'h520);
		`CHK("wr", 21'h1520ff, {file_wr_en, file_wr_addr, file_wr_data})
		`CHK("nza", 10'h100, {flag_neg, flag_zero, accum})
		$display("set tests done");
	endtask : t_set
	task automatic t_other;
		op(16'h0003, 8'h11, 12'h003);
		`CHK("other", 3'h4, {instr_other, instr_done, file_wr_en})
		@(posedge clk_sys);
		clk_en <= 1'b0;
		op(16'h4312, 8'hd7, 12'h512);
		`CHK("frozen", 3'h0, {instr_other, instr_done, file_wr_en})
		`CHK("held", 10'h100, {flag_neg, flag_zero, accum})
		@(posedge clk_sys);
		clk_en <= 1'b1;
		$display("other tests done");
	endtask : t_other
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// main sequence
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_rot;
		t_set;
		t_other;
		conclude;
	end
	// watchdog
	initial
	begin
		#20000;
		errors++;
		conclude;
	end
endmodule : rotate_right_and_set_ops_tb
`default_nettype wire
